/* core/wdw_count.sv */
// watchdog reference counter with period compare and window threshold
`timescale 1ns/10ps
module wdw_count #(
  parameter int CNT_W = 24
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic clear,
  input wire logic [4:0] period,
  input wire logic [2:0] window,
  output logic timeout,
  output logic window_open,
  output logic [CNT_W-1:0] count
);
  import wdw_pkg::*;

  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] thr;
  logic [CNT_W-1:0] eighth;
  logic [CNT_W-1:0] closed;
  logic at_end;

  // ==========================================================================
  // divider is 2^(code+5), code limited to 10010, so each code step up to 10010 doubles the timeout
  assign limit = {{(CNT_W-1){1'b0}}, 1'b1} <<
                 (DIV_BASE_EXP + wdw_eff_period(period));
  assign eighth = limit >> 3;
  assign closed = {{(CNT_W-3){1'b0}}, wdw_closed_eighths(window)};
  assign thr = eighth * closed;
  assign window_open = (count >= thr);
  assign at_end = (count == limit - {{(CNT_W-1){1'b0}}, 1'b1});

  // counts reference ticks while running, holds while suspended
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (run && tick) begin
      if (at_end) begin
        count <= '0;
      end else begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // one-cycle pulse when the divider count is reached without a clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timeout <= 1'b0;
    end else begin
      timeout <= run && tick && at_end && !clear;
    end
  end

endmodule

/* core/wdw_pkg.sv */
// package of constants, types and decode functions for the windowed watchdog
package wdw_pkg;

  // ==========================================================================
  // register bus geometry and offsets
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] ADDR_CTRL2 = 4'h2;
  localparam logic [3:0] ADDR_CLEAR = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h5;
  localparam logic [3:0] ADDR_KEY = 4'h6;
  localparam logic [3:0] ADDR_COUNT = 4'h7;
  localparam logic [3:0] ADDR_STATE = 4'h8;

  // ==========================================================================
  // configuration word layout and reset value
  localparam int CFG_CCS_LSB = 11;
  localparam int CFG_CWS_LSB = 8;
  localparam int CFG_MODE_LSB = 5;
  localparam int CFG_CPS_LSB = 0;
  localparam logic [15:0] CFG_RESET = 16'h3f7f;
  localparam logic [15:0] CFG_IMPL_MASK = 16'h3f7f;

  // control register fields
  localparam int CTRL1_SEN_BIT = 0;
  localparam int CTRL1_PER_LSB = 1;
  localparam int CTRL2_WIN_LSB = 0;
  localparam int CTRL2_CLK_BIT = 4;
  localparam int CTRL2_OPEN_BIT = 7;

  // status bits
  localparam int STS_TIMEOUT_BIT = 0;
  localparam int STS_EARLY_BIT = 1;

  // ==========================================================================
  // mode, clock, window and period codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [2:0] CCS_LF = 3'h0;
  localparam logic [2:0] CCS_MF = 3'h1;
  localparam logic [2:0] CCS_SOFT = 3'h7;
  localparam logic [2:0] CWS_SOFT = 3'h7;
  localparam logic [2:0] WIN_RESET = 3'h7;
  localparam logic [4:0] CPS_SOFT = 5'h1f;
  localparam logic [4:0] CPS_SOFT_LOAD = 5'h0b;
  localparam logic [4:0] CPS_MAX = 5'h12;
  localparam logic [4:0] DIV_BASE_EXP = 5'h05;

  // reference oscillator rates, for timeout estimates
  localparam int LF_OSC_HZ = 31000;
  localparam int MF_OSC_HZ = 31250;

  // keyed access sequence
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;

  typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_OPEN} wdw_key_t;

  // closed part of the period in eighths for a window code
  function automatic logic [2:0] wdw_closed_eighths(input logic [2:0] cws);
    logic [2:0] e;
    e = 3'h0;
    case (cws)
      3'h0: e = 3'h7;
      3'h1: e = 3'h6;
      3'h2: e = 3'h5;
      3'h3: e = 3'h4;
      3'h4: e = 3'h3;
      3'h5: e = 3'h2;
      default: e = 3'h0;
    endcase
    return e;
  endfunction

  // period code limited to the largest divider
  function automatic logic [4:0] wdw_eff_period(input logic [4:0] c);
    return (c > CPS_MAX) ? CPS_MAX : c;
  endfunction

endpackage

/* core/wdw_windowed_watchdog.sv */
// windowed watchdog top: configuration decode, control registers, events
//
// Behaviour
// - mode 00 keeps watchdog off, ignores enable, clock
// - mode 11 runs awake and asleep
// - mode 10 runs awake, suspends in sleep
// - mode 01 follows software enable bit
// - clock codes 000, 010-110 pick low oscillator
// - code 001 picks mid oscillator; 111 software
// - window code sets closed eighths of period
// - window changes free only with code 111
// - period codes up to 10010 load directly
// - period code 11111 loads 01011, software-changeable
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module wdw_windowed_watchdog #(
  parameter int CNT_W = 24
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [wdw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wdw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [wdw_pkg::DATA_W-1:0] reg_rdata,
  input wire logic lf_osc_tick,
  input wire logic mf_osc_tick,
  input wire logic sleep_active,
  output logic wdog_sys_reset,
  output logic wdog_running,
  output logic irq
);
  import wdw_pkg::*;

  // ==========================================================================
  // state
  logic [15:0] watchdog_config_word;
  logic runtime_software_enable;
  logic [4:0] runtime_period_field;
  logic [2:0] runtime_window;
  logic sw_clk_mf;
  logic [1:0] status;
  logic [1:0] mask;
  wdw_key_t key_state;
  logic run;

  logic [1:0] wdog_operating_mode;
  logic [2:0] wdog_clock_source_select;
  logic [2:0] wdog_window_size_select;
  logic [4:0] wdog_period_select;
  logic wr_cfg, wr_ctrl1, wr_ctrl2, wr_clear, wr_status, wr_mask, wr_key;
  logic enabled, next_run, sel_mf, ref_tick;
  logic clr_req, early, timeout, window_open, cnt_clear;
  logic win_wr_ok;
  logic [1:0] next_status;
  logic [CNT_W-1:0] count;

  // ==========================================================================
  // configuration word fields
  assign wdog_operating_mode = watchdog_config_word[CFG_MODE_LSB +: 2];
  assign wdog_clock_source_select = watchdog_config_word[CFG_CCS_LSB +: 3];
  assign wdog_window_size_select = watchdog_config_word[CFG_CWS_LSB +: 3];
  assign wdog_period_select = watchdog_config_word[CFG_CPS_LSB +: 5];

  // write strobes decoded per register
  always_comb begin
    wr_cfg = 1'b0;
    wr_ctrl1 = 1'b0;
    wr_ctrl2 = 1'b0;
    wr_clear = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    wr_key = 1'b0;
    if (reg_wr && reg_addr == ADDR_CFG) begin
      wr_cfg = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_CTRL1) begin
      wr_ctrl1 = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_CTRL2) begin
      wr_ctrl2 = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_CLEAR) begin
      wr_clear = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_STATUS) begin
      wr_status = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_wr && reg_addr == ADDR_KEY) begin
      wr_key = 1'b1;
    end
  end

  // ==========================================================================
  // operating mode decode
  always_comb begin
    enabled = 1'b0;
    next_run = 1'b0;
    case (wdog_operating_mode)
      MODE_OFF: begin
        enabled = 1'b0;
        next_run = 1'b0;
      end
      MODE_SW: begin
        enabled = runtime_software_enable;
        next_run = runtime_software_enable;
      end
      MODE_AWAKE: begin
        enabled = 1'b1;
        next_run = !sleep_active;
      end
      default: begin
        enabled = 1'b1;
        next_run = 1'b1;
      end
    endcase
  end

  // registered run level feeds the counter and the running output
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      wdog_running <= 1'b0;
    end else begin
      run <= next_run;
      wdog_running <= next_run;
    end
  end

  // reference clock choice; reserved codes fall back to the low oscillator
  assign sel_mf = (wdog_clock_source_select == CCS_MF) ||
                  (wdog_clock_source_select == CCS_SOFT && sw_clk_mf);
  assign ref_tick = sel_mf ? mf_osc_tick : lf_osc_tick;

  // ==========================================================================
  // configuration word; a write reloads the runtime period and window as at power-on, not the software enable or clock choice
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_config_word <= CFG_RESET;
    end else if (wr_cfg) begin
      watchdog_config_word <= reg_wdata & CFG_IMPL_MASK;
    end
  end

  // software enable and runtime period
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      runtime_software_enable <= 1'b0;
      runtime_period_field <= CPS_SOFT_LOAD;
    end else if (wr_cfg) begin
      if (reg_wdata[CFG_CPS_LSB +: 5] == CPS_SOFT) begin
        runtime_period_field <= CPS_SOFT_LOAD;
      end else begin
        runtime_period_field <= reg_wdata[CFG_CPS_LSB +: 5];
      end
    end else if (wr_ctrl1) begin
      runtime_software_enable <= reg_wdata[CTRL1_SEN_BIT];
      if (wdog_period_select == CPS_SOFT) begin
        runtime_period_field <= reg_wdata[CTRL1_PER_LSB +: 5];
      end
    end
  end

  // window writes need code 111 or an open key sequence
  assign win_wr_ok = (wdog_window_size_select == CWS_SOFT) ||
                     (key_state == KEY_OPEN);

  // runtime window and software clock choice
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      runtime_window <= WIN_RESET;
      sw_clk_mf <= 1'b0;
    end else if (wr_cfg) begin
      runtime_window <= reg_wdata[CFG_CWS_LSB +: 3];
    end else if (wr_ctrl2) begin
      if (win_wr_ok) begin
        runtime_window <= reg_wdata[CTRL2_WIN_LSB +: 3];
      end
      if (wdog_clock_source_select == CCS_SOFT) begin
        sw_clk_mf <= reg_wdata[CTRL2_CLK_BIT];
      end
    end
  end

  // keyed access: two key writes open one window write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      key_state <= KEY_IDLE;
    end else begin
      case (key_state)
        KEY_IDLE: begin
          if (wr_key && reg_wdata == KEY_FIRST) begin
            key_state <= KEY_ONE;
          end
        end
        KEY_ONE: begin
          if (wr_key && reg_wdata == KEY_SECOND) begin
            key_state <= KEY_OPEN;
          end else if (reg_wr) begin
            key_state <= KEY_IDLE;
          end
        end
        default: begin
          if (wr_ctrl2 || wr_key || wr_cfg) begin
            key_state <= KEY_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // counter and reset events
  assign clr_req = wr_clear && reg_wdata[0];
  assign early = clr_req && run && !window_open;
  assign cnt_clear = clr_req || !enabled || wr_cfg;

  wdw_count #(
    .CNT_W(CNT_W)
  ) u_count (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick(ref_tick),
    .run(run),
    .clear(cnt_clear),
    .period(runtime_period_field),
    .window(runtime_window),
    .timeout(timeout),
    .window_open(window_open),
    .count(count)
  );

  // system reset request pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wdog_sys_reset <= 1'b0;
    end else begin
      wdog_sys_reset <= timeout || early;
    end
  end

  // ==========================================================================
  // sticky status, set wins over a write-one clear
  always_comb begin
    next_status = status;
    if (wr_status) begin
      next_status = status & ~reg_wdata[1:0];
    end
    if (timeout) begin
      next_status[STS_TIMEOUT_BIT] = 1'b1;
    end
    if (early) begin
      next_status[STS_EARLY_BIT] = 1'b1;
    end
  end

  // status, mask and interrupt level
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status <= 2'h0;
      mask <= 2'h0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= reg_wdata[1:0];
      end
      irq <= |(next_status & (wr_mask ? reg_wdata[1:0] : mask));
    end
  end

  // ==========================================================================
  // read data, one cycle after the read strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == ADDR_CFG) begin
      reg_rdata <= watchdog_config_word;
    end else if (reg_addr == ADDR_CTRL1) begin
      reg_rdata <= {10'h000, runtime_period_field, runtime_software_enable};
    end else if (reg_addr == ADDR_CTRL2) begin
      reg_rdata <= {8'h00, window_open, 2'h0, sw_clk_mf, 1'b0,
                    runtime_window};
    end else if (reg_addr == ADDR_STATUS) begin
      reg_rdata <= {14'h0000, status};
    end else if (reg_addr == ADDR_MASK) begin
      reg_rdata <= {14'h0000, mask};
    end else if (reg_addr == ADDR_COUNT) begin
      reg_rdata <= count[CNT_W-1 -: 16];
    end else if (reg_addr == ADDR_STATE) begin
      reg_rdata <= {12'h000, sel_mf, key_state == KEY_OPEN, window_open, run};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  mode_off_a: assert property (
    (wdog_operating_mode == MODE_OFF) ##1 (wdog_operating_mode == MODE_OFF)
    |-> !run && !wdog_running)
    else $error("watchdog runs in off mode");

  mode_always_a: assert property (
    (wdog_operating_mode == MODE_ALWAYS) ##1
    (wdog_operating_mode == MODE_ALWAYS) |=> run)
    else $error("watchdog stopped in always-on mode");

  awake_only_a: assert property (
    (wdog_operating_mode == MODE_AWAKE) ##1
    (wdog_operating_mode == MODE_AWAKE) |-> run == !$past(sleep_active))
    else $error("awake-only mode does not follow sleep");

  sw_enable_a: assert property (
    (wdog_operating_mode == MODE_SW && !wr_ctrl1 && !wr_cfg) ##1
    (wdog_operating_mode == MODE_SW) |-> run == runtime_software_enable)
    else $error("software mode does not follow enable bit");

  lf_select_a: assert property (
    (wdog_clock_source_select != CCS_MF &&
     wdog_clock_source_select != CCS_SOFT) |-> ref_tick == lf_osc_tick)
    else $error("low oscillator not selected");

  mf_select_a: assert property (
    (wdog_clock_source_select == CCS_MF) |-> ref_tick == mf_osc_tick)
    else $error("mid oscillator not selected");

  window_close_a: assert property (
    (clr_req && wdw_closed_eighths(runtime_window) != 3'h0 && !wr_ctrl2 &&
     !wr_cfg) |=> !window_open [*2])
    else $error("window open right after a clear");

  window_lock_a: assert property (
    (wr_ctrl2 && !wr_cfg && wdog_window_size_select != CWS_SOFT &&
     key_state != KEY_OPEN) |=> $stable(runtime_window))
    else $error("locked window changed");

  period_load_a: assert property (
    (wdog_period_select <= CPS_MAX) |-> runtime_period_field ==
    wdog_period_select)
    else $error("runtime period differs from configured code");

  period_lock_a: assert property (
    (wr_ctrl1 && wdog_period_select != CPS_SOFT) |=>
    $stable(runtime_period_field))
    else $error("locked period changed");

  timeout_count_a: assert property (
    timeout |-> $past(count) == (({{(CNT_W-1){1'b0}}, 1'b1} <<
    (DIV_BASE_EXP + wdw_eff_period($past(runtime_period_field)))) -
    {{(CNT_W-1){1'b0}}, 1'b1}))
    else $error("timeout not at divider count");

  early_reset_a: assert property (
    early |=> wdog_sys_reset && status[STS_EARLY_BIT] ##1 !wdog_sys_reset)
    else $error("early clear did not reset");

  timeout_reset_a: assert property (
    timeout |=> wdog_sys_reset && status[STS_TIMEOUT_BIT])
    else $error("timeout did not reset");

  cov_timeout_c: cover property (timeout ##1 wdog_sys_reset);
  cov_early_c: cover property (early);
  cov_good_clear_c: cover property (clr_req && run && window_open);
  cov_key_open_c: cover property (key_state == KEY_OPEN ##1 wr_ctrl2);

endmodule

/* verification/wdw_windowed_watchdog_bench.sv */
// self-checking bench for the windowed watchdog configuration decode
`timescale 1ns/10ps
module wdw_windowed_watchdog_bench;
  import wdw_pkg::*;

  // ==========================================================================
  // stimulus, observation and bookkeeping
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic lf_osc_tick = 1'b0;
  logic mf_osc_tick = 1'b0;
  logic sleep_active = 1'b0;
  logic wdog_sys_reset, wdog_running, irq;
  logic [15:0] rv;
  int n_errors = 0;
  int compares = 0;
  int n_rst = 0;

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  wdw_windowed_watchdog #(.CNT_W(24)) dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .lf_osc_tick(lf_osc_tick),
    .mf_osc_tick(mf_osc_tick),
    .sleep_active(sleep_active),
    .wdog_sys_reset(wdog_sys_reset),
    .wdog_running(wdog_running),
    .irq(irq)
  );

  // count system reset pulses requested by the watchdog
  always @(posedge clk_sys) begin
    if (wdog_sys_reset === 1'b1) begin
      n_rst <= n_rst + 1;
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one-cycle write strobe; a gap cycle keeps strobes from colliding
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe; taken at its end
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  // exactly n ticks driven on the oscillators picked by l and m
  task automatic ticks(input logic l, input logic m, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      lf_osc_tick <= l;
      mf_osc_tick <= m;
    end
    @(posedge clk_sys);
    lf_osc_tick <= 1'b0;
    mf_osc_tick <= 1'b0;
  endtask

  // no reset one tick short of the divider, one reset on the last tick
  task automatic period_edge(input int div, input logic l, input logic m);
    int b;
    b = n_rst;
    ticks(l, m, div - 1);
    idle(3);
    chk(16'(n_rst - b), 16'h0000);
    ticks(l, m, 1);
    idle(3);
    chk(16'(n_rst - b), 16'h0001);
  endtask

  function automatic logic [15:0] cfg(input logic [1:0] m,
      input logic [2:0] c, input logic [2:0] w, input logic [4:0] p);
    return {2'b00, c, w, 1'b0, m, p};
  endfunction

  // closed eighths of the period for a window code
  function automatic int closed8(input logic [2:0] w);
    return (w >= 3'h6) ? 0 : 7 - int'(w);
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    int b;
    int e;
    logic [1:0] m;
    logic [4:0] p;
    logic en, sl, want, l;
    void'($urandom(32'h1404));
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    idle(2);
    // reset values and an unmapped address
    rd(ADDR_CFG, rv);
    chk(rv, 16'h3f7f);
    rd(ADDR_CTRL1, rv);
    chk(rv, 16'h0016);
    rd(4'hf, rv);
    chk(rv, 16'h0000);
    // every mode against both sleep states and both enable values
    for (int i = 0; i < 16; i++) begin
      m = 2'(i);
      sl = 1'(i >> 2);
      en = 1'(i >> 3);
      want = (m == 2'h3) || (m == 2'h2 && !sl) || (m == 2'h1 && en);
      sleep_active <= sl;
      wr(ADDR_CFG, cfg(m, 3'h0, 3'h7, 5'h00));
      wr(ADDR_CTRL1, {15'h0000, en});
      idle(3);
      chk({15'h0000, wdog_running}, {15'h0000, want});
      b = n_rst;
      ticks(1'b1, 1'b0, 32);
      idle(3);
      chk(16'(n_rst - b), {15'h0000, want});
    end
    sleep_active <= 1'b0;
    // period codes load directly and stay locked; random codes among them
    for (int i = 0; i < 7; i++) begin
      p = (i < 3) ? 5'(i) : 5'($urandom() % 19);
      wr(ADDR_CFG, cfg(2'h3, 3'h0, 3'h7, p));
      rd(ADDR_CTRL1, rv);
      chk({11'h000, rv[5:1]}, {11'h000, p});
      wr(ADDR_CTRL1, {10'h000, ~p, 1'b0});
      rd(ADDR_CTRL1, rv);
      chk({11'h000, rv[5:1]}, {11'h000, p});
      if (i < 3) begin
        period_edge(32 << i, 1'b1, 1'b0);
      end
    end
    // software period code loads 01011 and then follows software
    wr(ADDR_CFG, cfg(2'h3, 3'h0, 3'h7, 5'h1f));
    rd(ADDR_CTRL1, rv);
    chk({11'h000, rv[5:1]}, 16'h000b);
    wr(ADDR_CTRL1, 16'h0002);
    rd(ADDR_CTRL1, rv);
    chk({11'h000, rv[5:1]}, 16'h0001);
    period_edge(64, 1'b1, 1'b0);
    // every clock source code; the unselected oscillator must not count
    for (int c = 0; c < 8; c++) begin
      l = !(c == 1 || c == 7);
      wr(ADDR_CFG, cfg(2'h3, 3'(c), 3'h7, 5'h00));
      if (c == 7) begin
        wr(ADDR_CTRL2, 16'h0017);
      end
      b = n_rst;
      ticks(!l, l, 40);
      idle(3);
      chk(16'(n_rst - b), 16'h0000);
      period_edge(32, l, !l);
    end
    // clear exactly at the window opening for every code, and just before it for codes 000-101
    for (int w = 0; w < 8; w++) begin
      e = closed8(3'(w));
      if (e > 0) begin
        wr(ADDR_CFG, cfg(2'h3, 3'h0, 3'(w), 5'h00));
        b = n_rst;
        ticks(1'b1, 1'b0, 4 * e - 1);
        wr(ADDR_CLEAR, 16'h0001);
        idle(3);
        chk(16'(n_rst - b), 16'h0001);
      end
      wr(ADDR_CFG, cfg(2'h3, 3'h0, 3'(w), 5'h00));
      b = n_rst;
      ticks(1'b1, 1'b0, 4 * e);
      wr(ADDR_CLEAR, 16'h0001);
      idle(3);
      chk(16'(n_rst - b), 16'h0000);
    end
    // early clear event: sticky status, mask, clear by writing one
    rd(ADDR_STATUS, rv);
    chk(rv & 16'h0002, 16'h0002);
    chk({15'h0000, irq}, 16'h0000);
    wr(ADDR_MASK, 16'h0002);
    idle(2);
    chk({15'h0000, irq}, 16'h0001);
    wr(ADDR_STATUS, 16'h0003);
    idle(2);
    chk({15'h0000, irq}, 16'h0000);
    rd(ADDR_STATUS, rv);
    chk(rv, 16'h0000);
    // window locked without the key, open with it or with code 111
    wr(ADDR_CFG, cfg(2'h3, 3'h0, 3'h3, 5'h00));
    wr(ADDR_CTRL2, 16'h0007);
    rd(ADDR_CTRL2, rv);
    chk({13'h0000, rv[2:0]}, 16'h0003);
    wr(ADDR_KEY, 16'h0055);
    wr(ADDR_KEY, 16'h00aa);
    wr(ADDR_CTRL2, 16'h0007);
    rd(ADDR_CTRL2, rv);
    chk({13'h0000, rv[2:0]}, 16'h0007);
    wr(ADDR_CFG, cfg(2'h3, 3'h0, 3'h7, 5'h00));
    wr(ADDR_CTRL2, 16'h0002);
    rd(ADDR_CTRL2, rv);
    chk({13'h0000, rv[2:0]}, 16'h0002);
    end_sim();
  end

  // cut a hang short
  initial begin
    #1000000;
    n_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim();
  end
endmodule
